// ==== shared/sec_pkg.sv ====
package sec_pkg;
    // Control byte codes in the upper nibble.
    localparam logic [3:0] CODE_MEMORY  = 4'ha;
    localparam logic [3:0] CODE_PROTECT = 4'h6;
    localparam int         CODE_MSB     = 7;
    localparam int         CODE_LSB     = 4;
    localparam int         CS_MSB       = 3;
    localparam int         CS_LSB       = 1;
    localparam int         RW_BIT       = 0;
    localparam logic       RW_READ      = 1'b1;
    // Array geometry.
    localparam int         MEM_DEPTH    = 256;
    localparam int         PAGE_BYTES   = 16;
    localparam int         PAGE_BITS    = 4;
    localparam int         LOWER_BIT    = 7;
    // Bit counter: eight data bits then the acknowledge slot.
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;
    // Internal write cycle time in its own unit and in system clocks.
    localparam int         WRITE_TIME_MS   = 5;
    localparam int         CLOCK_MHZ       = 100;
    localparam int         WRITE_CYCLES    = WRITE_TIME_MS * CLOCK_MHZ * 1000;
    // Protection command kinds, selected by the chip-select bits.
    typedef enum logic [1:0] {CMD_NONE, CMD_LOCK, CMD_UNLOCK, CMD_PERM} sec_cmd_type;
    localparam logic [2:0] CS_LOCK   = 3'h1;
    localparam logic [2:0] CS_UNLOCK = 3'h3;
    typedef enum {ST_IDLE, ST_CTRL, ST_ADDR, ST_DATA, ST_READ, ST_IGNORE} sec_state_type;
endpackage

// ==== shared/sec_commit_if.sv ====
`timescale 1ns/1ps
// Carries the completed write request from the link domain to the core.
interface sec_commit_if;
    logic                 toggle;
    logic [7:0]           baseAddr;
    logic [4:0]           count;
    logic [7:0]           data [16];
    logic                 protCmd;
    logic [1:0]           protKind;
    logic                 busy;
    modport link (output toggle, output baseAddr, output count, output data,
                  output protCmd, output protKind, input busy);
    modport core (input toggle, input baseAddr, input count, input data,
                  input protCmd, input protKind, output busy);
endinterface

// ==== design/sec_write_core.sv ====
`timescale 1ns/1ps
// Runs the self-timed write cycle on the system clock and owns the array.
module sec_write_core
    import sec_pkg::*;
#(
    parameter int CYCLES = WRITE_CYCLES
) (
    input  wire logic    clock,
    input  wire logic    reset,
    input  wire logic    enable,
    input  wire logic    protectSync,
    sec_commit_if.core   cmt,
    output logic         lockSoft,
    output logic         lockPerm,
    output logic [7:0]   memory [MEM_DEPTH]
);
    logic [2:0]  togSync_reg, togSync_next;
    logic [31:0] timer_reg, timer_next;
    logic        lockSoft_reg, lockSoft_next, lockPerm_reg, lockPerm_next;
    logic [7:0]  mem_reg [MEM_DEPTH];
    logic [7:0]  mem_next [MEM_DEPTH];
    logic [7:0]  addr;
    logic        start;

    // The toggle passes two flops; the edge is seen between the second and third.
    assign start = togSync_reg[2] ^ togSync_reg[1];

    // Write cycle, lock state and array commit; the array writes in the first cycle.
    always_comb begin
        togSync_next  = {togSync_reg[1:0], cmt.toggle};
        timer_next    = timer_reg;
        lockSoft_next = lockSoft_reg;
        lockPerm_next = lockPerm_reg;
        mem_next      = mem_reg;
        addr          = 8'h00;
        if (timer_reg != 32'h0) begin
            timer_next = timer_reg - 32'h1;
        end
        if (start) begin
            // The start cycle itself is the first busy cycle, so the timer loads one less.
            timer_next = 32'(CYCLES - 1);
            if (cmt.protCmd) begin
                unique case (cmt.protKind)
                    CMD_LOCK:   lockSoft_next = 1'b1;
                    CMD_UNLOCK: lockSoft_next = 1'b0;
                    CMD_PERM:   lockPerm_next = 1'b1;
                    default:    lockSoft_next = lockSoft_reg;
                endcase
            end else if (!protectSync) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    // The pointer has moved past the last byte; walk back by the count.
                    addr = {cmt.baseAddr[7:PAGE_BITS],
                            cmt.baseAddr[PAGE_BITS-1:0] - cmt.count[PAGE_BITS-1:0] + 4'(i)};
                    // Lower half stays untouched under either lock.
                    if (5'(i) < cmt.count &&
                        !(addr[LOWER_BIT] == 1'b0 && (lockSoft_reg || lockPerm_reg))) begin
                        mem_next[addr] = cmt.data[addr[PAGE_BITS-1:0]];
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            togSync_reg  <= 3'h0;
            timer_reg    <= 32'h0;
            lockSoft_reg <= 1'b0;
            lockPerm_reg <= 1'b0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_reg[i] <= 8'hff;
            end
        end else if (enable) begin
            togSync_reg  <= togSync_next;
            timer_reg    <= timer_next;
            lockSoft_reg <= lockSoft_next;
            lockPerm_reg <= lockPerm_next;
            mem_reg      <= mem_next;
        end
    end

    assign cmt.busy = (timer_reg != 32'h0) || start;
    assign lockSoft = lockSoft_reg;
    assign lockPerm = lockPerm_reg;
    assign memory   = mem_reg;
endmodule

// ==== design/sec_client.sv ====
`timescale 1ns/1ps
module sec_client
    import sec_pkg::*;
#(
    parameter int WRITE_CLOCKS = WRITE_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic scl,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    input  wire logic chip_select_pin_0,
    input  wire logic chip_select_pin_1,
    input  wire logic chip_select_pin_2,
    input  wire logic high_voltage_level,
    input  wire logic writeProtect,
    output logic      busy,
    output logic      lockSoft,
    output logic      lockPerm
);
    sec_commit_if cmt();
    logic [7:0] memory [MEM_DEPTH];

    // Straps and the permanent lock pass two flops on the serial clock, link side; the protect pin passes four on the system clock.
    logic [4:0] strapMeta_reg, strapSync_reg;
    logic [1:0] busyMeta_reg, busySync_reg;
    logic [1:0] protMeta_reg, protSync_reg;
    logic [2:0] pins;
    logic       hv, busyLink, protectSync, permLink;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            protMeta_reg <= 2'h0;
            protSync_reg <= 2'h0;
        end else if (enable) begin
            protMeta_reg <= {protMeta_reg[0], writeProtect};
            protSync_reg <= {protSync_reg[0], protMeta_reg[1]};
        end
    end
    assign protectSync = protSync_reg[1];

    // The link logic runs on the host clock; data is sampled on its rising edge.
    // Start and stop are caught by the data line edge while the clock is high.
    logic       startSeen_reg, startSeen_next;
    logic       stopSeen_reg;
    logic       startClr_reg, stopClr_reg;

    // Start latch: data falling while clock high.
    always_ff @(negedge sdaIn or posedge reset) begin
        if (reset) begin
            startSeen_reg <= 1'b0;
        end else begin
            startSeen_reg <= startSeen_next;
        end
    end
    always_comb begin
        startSeen_next = scl ? ~startClr_reg : startSeen_reg;
    end

    // Stop latch: data rising while clock high.
    always_ff @(posedge sdaIn or posedge reset) begin
        if (reset) begin
            stopSeen_reg <= 1'b0;
        end else if (scl) begin
            stopSeen_reg <= ~stopClr_reg;
        end
    end

    sec_state_type state_reg, state_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] addr_reg, addr_next;
    logic [4:0] count_reg, count_next;
    logic [7:0] buf_reg [PAGE_BYTES];
    logic [7:0] buf_next [PAGE_BYTES];
    logic       prot_reg, prot_next;
    logic [1:0] kind_reg, kind_next;
    logic       ack_reg, ack_next;
    logic       tog_reg, tog_next;
    logic       stClr_next, spClr_next;
    logic       csMatch, codeOk, gotStart, gotStop;
    logic [1:0] kindSel;

    assign gotStart = startSeen_reg ^ startClr_reg;
    assign gotStop  = stopSeen_reg ^ stopClr_reg;
    assign pins     = strapSync_reg[2:0];
    assign hv       = strapSync_reg[3];
    assign busyLink = busySync_reg[1];
    assign permLink = strapSync_reg[4];
    assign csMatch  = shift_reg[CS_MSB-1:0] == pins;

    // Protection kind from the chip-select bits and the high voltage strap.
    always_comb begin
        kindSel = CMD_PERM;
        if (hv && shift_reg[CS_MSB-1:0] == CS_LOCK) begin
            kindSel = CMD_LOCK;
        end else if (hv && shift_reg[CS_MSB-1:0] == CS_UNLOCK) begin
            kindSel = CMD_UNLOCK;
        end
    end
    assign codeOk = (shift_reg[6:3] == CODE_MEMORY && csMatch) ||
                    (shift_reg[6:3] == CODE_PROTECT && !permLink &&
                     (kindSel != CMD_PERM || csMatch) && sdaIn != RW_READ);

    // Byte engine on the rising clock edge.
    always_comb begin
        state_next  = state_reg;
        bitCnt_next = bitCnt_reg;
        shift_next  = shift_reg;
        addr_next   = addr_reg;
        count_next  = count_reg;
        buf_next    = buf_reg;
        prot_next   = prot_reg;
        kind_next   = kind_reg;
        ack_next    = 1'b0;
        tog_next    = tog_reg;
        stClr_next  = startClr_reg;
        spClr_next  = stopClr_reg;
        if (gotStop) begin
            spClr_next = stopSeen_reg;
            state_next = ST_IDLE;
            if (count_reg != 5'h0 || prot_reg) begin
                tog_next = ~tog_reg;
            end
            // Count and kind stay put so the core reads them after the toggle crosses.
        end
        if (gotStart) begin
            stClr_next  = startSeen_reg;
            state_next  = ST_CTRL;
            // The rise that consumes the start also carries the first control bit.
            shift_next  = {shift_reg[6:0], sdaIn};
            bitCnt_next = 4'h1;
            count_next  = 5'h0;
            prot_next   = 1'b0;
        end else if (state_reg != ST_IDLE && state_reg != ST_IGNORE && !gotStop) begin
            if (bitCnt_reg == BIT_ACK) begin
                bitCnt_next = 4'h0;
            end else begin
                shift_next  = {shift_reg[6:0], sdaIn};
                bitCnt_next = bitCnt_reg + 4'h1;
                if (bitCnt_reg == BIT_LAST) begin
                    ack_next = 1'b1;
                    unique case (state_reg)
                        ST_CTRL: begin
                            if (busyLink || !codeOk) begin
                                ack_next   = 1'b0;
                                state_next = ST_IGNORE;
                            end else if (sdaIn == RW_READ) begin
                                state_next = ST_READ;
                            end else begin
                                state_next = ST_ADDR;
                                prot_next  = shift_reg[6:3] == CODE_PROTECT;
                                kind_next  = kindSel;
                            end
                        end
                        ST_ADDR: begin
                            if (!prot_reg) begin
                                addr_next = {shift_reg[6:0], sdaIn};
                            end
                            state_next = ST_DATA;
                        end
                        ST_DATA: begin
                            if (!prot_reg) begin
                                buf_next[addr_reg[PAGE_BITS-1:0]] = {shift_reg[6:0], sdaIn};
                                addr_next[PAGE_BITS-1:0] = addr_reg[PAGE_BITS-1:0] + 4'h1;
                                if (count_reg != 5'(PAGE_BYTES)) begin
                                    count_next = count_reg + 5'h1;
                                end
                            end
                        end
                        default: ack_next = 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            state_reg     <= ST_IDLE;
            bitCnt_reg    <= 4'h0;
            shift_reg     <= 8'h00;
            addr_reg      <= 8'h00;
            count_reg     <= 5'h0;
            prot_reg      <= 1'b0;
            kind_reg      <= CMD_NONE;
            ack_reg       <= 1'b0;
            tog_reg       <= 1'b0;
            startClr_reg  <= 1'b0;
            stopClr_reg   <= 1'b0;
            strapMeta_reg <= 5'h0;
            strapSync_reg <= 5'h0;
            busyMeta_reg  <= 2'h0;
            busySync_reg  <= 2'h0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_reg[i] <= 8'h00;
            end
        end else begin
            state_reg     <= state_next;
            bitCnt_reg    <= bitCnt_next;
            shift_reg     <= shift_next;
            addr_reg      <= addr_next;
            count_reg     <= count_next;
            prot_reg      <= prot_next;
            kind_reg      <= kind_next;
            ack_reg       <= ack_next;
            tog_reg       <= tog_next;
            startClr_reg  <= stClr_next;
            stopClr_reg   <= spClr_next;
            buf_reg       <= buf_next;
            strapMeta_reg <= {lockPerm, high_voltage_level, chip_select_pin_2,
                              chip_select_pin_1, chip_select_pin_0};
            strapSync_reg <= strapMeta_reg;
            busyMeta_reg  <= {busyMeta_reg[0], cmt.busy};
            busySync_reg  <= {busySync_reg[0], busyMeta_reg[1]};
        end
    end

    // Acknowledge goes out on the falling edge so it changes only while the clock is low.
    logic ackDrive_reg;
    always_ff @(negedge scl or posedge reset) begin
        if (reset) begin
            ackDrive_reg <= 1'b0;
        end else begin
            ackDrive_reg <= ack_reg && !gotStart;
        end
    end

    // Open drain: the output is always low and only the enable moves.
    assign sdaOut = 1'b0;
    assign sdaOe  = ackDrive_reg;

    // Request words are held stable by the host-paced protocol while the toggle crosses.
    assign cmt.toggle   = tog_reg;
    assign cmt.baseAddr = addr_reg;
    assign cmt.count    = count_reg;
    assign cmt.data     = buf_reg;
    assign cmt.protCmd  = prot_reg;
    assign cmt.protKind = kind_reg;

    sec_write_core #(
        .CYCLES (WRITE_CLOCKS)
    ) core (
        .clock       (clock),
        .reset       (reset),
        .enable      (enable),
        .protectSync (protectSync),
        .cmt         (cmt.core),
        .lockSoft    (lockSoft),
        .lockPerm    (lockPerm),
        .memory      (memory)
    );
    assign busy = cmt.busy;
endmodule

// ==== tb/sec_client_props.sv ====
`timescale 1ns/1ps
// Watches the client's pins and flags; it sees only the top ports.
module sec_client_props
    import sec_pkg::*;
#(
    parameter int WRITE_CLOCKS = 50
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic busy,
    input wire logic lockSoft,
    input wire logic lockPerm
);
    logic       startTog;
    logic       seenTog;
    logic [3:0] slot;
    logic [3:0] slotNow;
    int         busyCnt;

    // A start flips a flag, so the clock-side counter restarts without a second driver.
    always_ff @(negedge sdaIn or posedge reset) begin
        if (reset)
            startTog <= 1'b0;
        else if (scl)
            startTog <= ~startTog;
    end

    // Index of the current clock rise inside a nine-pulse byte slot.
    always_comb begin
        if (startTog != seenTog || slot == 4'h9)
            slotNow = 4'h1;
        else
            slotNow = slot + 4'h1;
    end

    // Registers the slot index on each rise of the serial clock.
    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            slot    <= 4'h0;
            seenTog <= 1'b0;
        end else begin
            slot    <= slotNow;
            seenTog <= startTog;
        end
    end

    // Length of the running write cycle in system clocks.
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            busyCnt <= 0;
        else
            busyCnt <= busy ? busyCnt + 1 : 0;
    end

    a_sda_never_high: assert property (@(posedge clock) disable iff (reset)
        sdaOut == 1'b0) else $error("data line driven high");
    a_ack_ninth_slot: assert property (@(posedge scl) disable iff (reset)
        sdaOe |-> slotNow == 4'h9) else $error("acknowledge outside ninth pulse");
    a_ack_one_slot: assert property (@(posedge scl) disable iff (reset)
        sdaOe |=> !sdaOe) else $error("acknowledge held past its pulse");
    a_no_ack_busy: assert property (@(posedge clock) disable iff (reset)
        busy && $past(busy, 8) |-> !sdaOe) else $error("acknowledge during write cycle");
    a_busy_length: assert property (@(posedge clock) disable iff (reset)
        $fell(busy) |-> busyCnt == WRITE_CLOCKS) else $error("write cycle length wrong");
    a_busy_when_idle: assert property (@(posedge clock) disable iff (reset)
        $rose(busy) |-> scl && sdaIn) else $error("write cycle began inside a frame");
    a_perm_sticky: assert property (@(posedge clock) disable iff (reset)
        $past(lockPerm) |-> lockPerm) else $error("permanent lock cleared");
    a_soft_frozen: assert property (@(posedge clock) disable iff (reset)
        $past(lockPerm) |-> $stable(lockSoft)) else $error("soft lock moved after permanent");
    c_cycle_end: cover property (@(posedge clock) disable iff (reset) $fell(busy));
endmodule

// ==== tb/sec_host_model.sv ====
`timescale 1ns/1ps
// Bus host: owns the serial clock, which stands high between frames.
module sec_host_model (
    output logic      scl,
    output logic      sdaPull,
    input  wire logic sdaLine
);
    localparam realtime QTR = 3.75;

    // Idle bus: both lines high.
    initial begin
        scl     = 1'b1;
        sdaPull = 1'b0;
    end

    // Clock pulses with data released, so no condition is formed.
    task automatic idle_pulses(input int n);
        repeat (n) begin
            scl = 1'b0;
            #(2 * QTR);
            scl = 1'b1;
            #(2 * QTR);
        end
    endtask

    // Data falls while the clock is high.
    task automatic start_cond();
        sdaPull = 1'b1;
        #QTR;
        scl = 1'b0;
        #QTR;
    endtask

    // Eight bits MSB first, data changed only in the low phase, then the ninth pulse.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaPull = ~b[i];
            #QTR;
            scl = 1'b1;
            #(2 * QTR);
            scl = 1'b0;
            #QTR;
        end
        sdaPull = 1'b0;
        #QTR;
        scl = 1'b1;
        #QTR;
        ack = ~sdaLine;
        #QTR;
        scl = 1'b0;
        #QTR;
    endtask

    // Data rises while the clock is high; the client acts on it at one more rise.
    task automatic stop_cond();
        sdaPull = 1'b1;
        #QTR;
        scl = 1'b1;
        #QTR;
        sdaPull = 1'b0;
        #QTR;
        idle_pulses(1);
    endtask
endmodule

// ==== tb/sec_client_test.sv ====
`timescale 1ns/1ps
// Drives the client through the host model; checks acknowledges, write cycles and locks.
module sec_client_test
    import sec_pkg::*;
;
    localparam int WCLK = 50;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       enable = 1'b1;
    logic       scl;
    logic       sdaPull;
    logic       sdaLine;
    logic       sdaOut;
    logic       sdaOe;
    logic       busy;
    logic       lockSoft;
    logic       lockPerm;
    logic [2:0] chipPins = 3'h0;
    logic       hv = 1'b0;
    logic       wp = 1'b0;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         seed = 64228;

    always #5 clock = ~clock;

    // Open-drain line with a pull-up: low while either party pulls.
    assign sdaLine = (sdaPull || sdaOe) ? 1'b0 : 1'b1;

    sec_client #(.WRITE_CLOCKS(WCLK)) u_dut (
        .clock             (clock),
        .reset             (reset),
        .enable            (enable),
        .scl               (scl),
        .sdaIn             (sdaLine),
        .sdaOut            (sdaOut),
        .sdaOe             (sdaOe),
        .chip_select_pin_0 (chipPins[0]),
        .chip_select_pin_1 (chipPins[1]),
        .chip_select_pin_2 (chipPins[2]),
        .high_voltage_level(hv),
        .writeProtect      (wp),
        .busy              (busy),
        .lockSoft          (lockSoft),
        .lockPerm          (lockPerm)
    );
    sec_host_model u_host (.scl(scl), .sdaPull(sdaPull), .sdaLine(sdaLine));

    task automatic check_bit(input string what, input logic expv, input logic got);
        cmp_count++;
        if (got !== expv) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", what, expv, got);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bounded wait; running out of cycles ends the run.
    task automatic wait_busy(input logic level, input int limit);
        int n;
        n = 0;
        cmp_count++;
        while (busy !== level && n < limit) begin
            @(posedge clock);
            n++;
        end
        if (busy !== level) begin
            error_cnt++;
            $display("MISMATCH busy wait expected %b seen %b", level, busy);
            test_done();
        end
    endtask

    // Inputs change a fixed delay after the clock edge; straps then sync on scl.
    task automatic set_pins(input logic [2:0] p, input logic hvLevel, input logic wpLevel);
        @(posedge clock);
        #1;
        chipPins = p;
        hv       = hvLevel;
        wp       = wpLevel;
        u_host.idle_pulses(3);
    endtask

    function automatic logic exp_ctrl_ack(input logic [7:0] c, input logic [2:0] p);
        return c[CODE_MSB:CODE_LSB] == CODE_MEMORY && c[CS_MSB:CS_LSB] == p;
    endfunction

    // Control byte; address and nData data bytes only when expAck is set for a write control; then stop.
    task automatic write_frame(input logic [7:0] c, input logic [7:0] a, input int nData,
                               input logic expAck);
        logic ack;
        u_host.start_cond();
        u_host.send_byte(c, ack);
        check_bit("control ack", expAck, ack);
        if (expAck === 1'b1 && c[RW_BIT] !== RW_READ) begin
            u_host.send_byte(a, ack);
            check_bit("address ack", 1'b1, ack);
            for (int i = 0; i < nData; i++) begin
                u_host.send_byte(8'($random(seed)), ack);
                check_bit("data ack", 1'b1, ack);
            end
        end
        u_host.stop_cond();
    endtask

    // A write cycle must run to its end; otherwise busy must read low 20 clocks later.
    task automatic cycle_done(input logic expCycle);
        if (expCycle) begin
            wait_busy(1'b1, 20);
            wait_busy(1'b0, WCLK + 20);
        end else begin
            repeat (20) @(posedge clock);
            check_bit("no write cycle", 1'b0, busy);
        end
    endtask

    initial begin
        logic [7:0] ctrl;
        logic       expAck;
        repeat (3) @(posedge clock);
        #1;
        reset = 1'b0;
        u_host.idle_pulses(3);
        check_bit("busy after reset", 1'b0, busy);
        check_bit("permanent lock after reset", 1'b0, lockPerm);
        // Random addressing: wrong codes, wrong selects, reads and writes.
        for (int t = 0; t < 12; t++) begin
            set_pins(3'($random(seed)), 1'b0, 1'b0);
            ctrl = 8'($random(seed));
            if (t % 3 != 2)
                ctrl[7:4] = CODE_MEMORY;
            if (t % 2 == 0)
                ctrl[3:1] = chipPins;
            if (ctrl[7:4] == CODE_PROTECT)
                ctrl[7:4] = 4'h0;
            expAck = exp_ctrl_ack(ctrl, chipPins);
            write_frame(ctrl, 8'($random(seed)), 1 + t % 2, expAck);
            cycle_done(expAck && ctrl[RW_BIT] == 1'b0);
        end
        // Overlong page, then an address attempt while the cycle runs.
        set_pins(3'h5, 1'b0, 1'b0);
        write_frame({CODE_MEMORY, 3'h5, 1'b0}, 8'h7c, PAGE_BYTES + 1, 1'b1);
        wait_busy(1'b1, 20);
        write_frame({CODE_MEMORY, 3'h5, 1'b0}, 8'h00, 1, 1'b0);
        wait_busy(1'b0, WCLK + 20);
        // Hardware protect: bytes still acknowledged, full cycle time observed.
        set_pins(3'h5, 1'b0, 1'b1);
        write_frame({CODE_MEMORY, 3'h5, 1'b0}, 8'hf0, 1, 1'b1);
        repeat (WCLK + 40) @(posedge clock);
        set_pins(CS_LOCK, 1'b1, 1'b0);
        write_frame({CODE_PROTECT, CS_LOCK, 1'b0}, 8'h00, 1, 1'b1);
        cycle_done(1'b1);
        check_bit("soft lock set", 1'b1, lockSoft);
        set_pins(CS_UNLOCK, 1'b1, 1'b0);
        write_frame({CODE_PROTECT, CS_UNLOCK, 1'b0}, 8'h5a, 1, 1'b1);
        cycle_done(1'b1);
        check_bit("soft lock cleared", 1'b0, lockSoft);
        set_pins(3'h2, 1'b0, 1'b0);
        write_frame({CODE_PROTECT, 3'h2, 1'b0}, 8'h00, 1, 1'b1);
        cycle_done(1'b1);
        check_bit("permanent lock", 1'b1, lockPerm);
        set_pins(CS_LOCK, 1'b1, 1'b0);
        write_frame({CODE_PROTECT, CS_LOCK, 1'b0}, 8'h00, 1, 1'b0);
        cycle_done(1'b0);
        check_bit("soft lock after permanent", 1'b0, lockSoft);
        test_done();
    end
endmodule

bind sec_client sec_client_props #(.WRITE_CLOCKS(WRITE_CLOCKS)) u_props (
    .clock   (clock),
    .reset   (reset),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .busy    (busy),
    .lockSoft(lockSoft),
    .lockPerm(lockPerm)
);
